// ---- common/clkbuf_regs_pkg.sv ----
// Register map constants and carrier types for the clock buffer register bank
// Assumes a 32-bit AHB-Lite slave holding 16-bit registers in the low bits
package clkbuf_regs_pkg;

	// ------------------------------------------------------------
	// Register geometry
	// ------------------------------------------------------------
	localparam int reg_width = 16;
	localparam int num_regs = 35;
	localparam int idx_width = 7;
	localparam logic [1:0] word_shift_zero = 2'h0;

	// ------------------------------------------------------------
	// Register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [idx_width-1:0] idx_top_control = 7'h00;
	localparam logic [idx_width-1:0] idx_oscillator_select_readback = 7'h41;
	localparam logic [idx_width-1:0] idx_lock_status_readback = 7'h4b;
	localparam logic [idx_width-1:0] idx_window_position_low = 7'h0b;
	localparam logic [idx_width-1:0] idx_window_position_high = 7'h0c;

	// Table of all mapped indices, entry order fixes the storage slot
	localparam logic [idx_width-1:0] reg_index [num_regs] = '{
		7'h00, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09,
		7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h11, 7'h12, 7'h13,
		7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h19, 7'h1c, 7'h1d, 7'h21,
		7'h22, 7'h41, 7'h43, 7'h48, 7'h4b, 7'h4f, 7'h56, 7'h5a
	};

	// Read-only slots are not written by software
	localparam logic [num_regs-1:0] reg_read_only = 35'h0_9000_0600;

	// Reset values, arbitrary plain defaults where none is given
	localparam logic [reg_width-1:0] reg_reset [num_regs] = '{
		16'h0000, 16'h0223, 16'hff86, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h5666, 16'h04c5, 16'h0000, 16'h51cb,
		16'h0000, 16'h0000, 16'h0104, 16'h0004, 16'h0006
	};

	// ------------------------------------------------------------
	// Top control fields
	// ------------------------------------------------------------
	localparam int top_reset_bit = 0;
	localparam int top_reserved_bit = 1;
	localparam int top_power_down_bit = 2;
	localparam logic [reg_width-1:0] top_writable_mask = 16'h0007;

	// Readback register layouts
	localparam logic [reg_width-1:0] osc_readback_fixed = 16'h4400;
	localparam int osc_field_lsb = 4;
	localparam int osc_field_width = 5;
	localparam logic [reg_width-1:0] lock_readback_fixed = 16'h0003;
	localparam int lock_field_lsb = 8;
	localparam int lock_field_width = 2;

	// ------------------------------------------------------------
	// AHB-Lite encodings
	// ------------------------------------------------------------
	localparam logic [1:0] htrans_nonseq = 2'h2;
	localparam logic [1:0] htrans_seq = 2'h3;

	// Pending data phase of a bus transfer
	typedef struct packed {
		logic active;
		logic write;
		logic [idx_width-1:0] index;
		logic aligned;
	} bus_phase_type;

	// Status inputs from the analog core
	typedef struct packed {
		logic [osc_field_width-1:0] oscillator_choice_readback;
		logic [lock_field_width-1:0] lock_indicator_readback;
		logic [31:0] window_position;
	} core_status_type;

endpackage

// ---- rtl/clock_buffer_register_map.sv ----
// Register bank of a multi-output clock buffer, reached over AHB-Lite
// Assumes one master, single word transfers, status inputs synchronous to hclk
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Functional notes
// - Power-down bit puts device in low power, all contents kept.
// - Soft reset bit returns every register to its power-on value, except the reset bit itself, which stays set.
// - Soft reset bit clears itself on the following write to a writable register.
// - Top control bits fifteen to three read as zero.
// - Top control resets to zero, power-down and reset inactive.
// - Oscillator choice readback register is read-only.
// - Lock status readback register is read-only.
module clock_buffer_register_map (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Core status
	input wire clkbuf_regs_pkg::core_status_type core_status,
	// Core controls
	output logic power_down,
	output logic soft_reset_active,
	output logic [clkbuf_regs_pkg::reg_width*clkbuf_regs_pkg::num_regs-1:0]
		reg_image
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		clkbuf_regs_pkg::bus_phase_type phase;
		logic [clkbuf_regs_pkg::num_regs-1:0]
			[clkbuf_regs_pkg::reg_width-1:0] regs;
		logic [31:0] rdata;
		logic power_down;
		logic soft_reset;
	} state_type;

	state_type state_q;
	state_type state_d;
	state_type state_reset;

	logic [clkbuf_regs_pkg::num_regs-1:0] hit_vec;
	logic [clkbuf_regs_pkg::num_regs-1:0] rd_hit_vec;
	logic [clkbuf_regs_pkg::idx_width-1:0] rd_index;
	logic [clkbuf_regs_pkg::reg_width-1:0] live_value
		[clkbuf_regs_pkg::num_regs];

	// ------------------------------------------------------------
	// Per-register decode and live value
	// ------------------------------------------------------------
	assign rd_index = haddr[clkbuf_regs_pkg::idx_width+1:2];

	genvar gi;
	generate
		for (gi = 0; gi < clkbuf_regs_pkg::num_regs; gi++) begin : g_reg
			assign hit_vec[gi] = state_q.phase.index ==
				clkbuf_regs_pkg::reg_index[gi];
			assign rd_hit_vec[gi] = rd_index == clkbuf_regs_pkg::reg_index[gi];
			if (clkbuf_regs_pkg::reg_index[gi] ==
				clkbuf_regs_pkg::idx_oscillator_select_readback) begin : g_osc
				assign live_value[gi] = clkbuf_regs_pkg::osc_readback_fixed |
					(clkbuf_regs_pkg::reg_width'(
					core_status.oscillator_choice_readback) <<
					clkbuf_regs_pkg::osc_field_lsb);
			end else if (clkbuf_regs_pkg::reg_index[gi] ==
				clkbuf_regs_pkg::idx_lock_status_readback) begin : g_lock
				assign live_value[gi] = clkbuf_regs_pkg::lock_readback_fixed |
					(clkbuf_regs_pkg::reg_width'(
					core_status.lock_indicator_readback) <<
					clkbuf_regs_pkg::lock_field_lsb);
			end else if (clkbuf_regs_pkg::reg_index[gi] ==
				clkbuf_regs_pkg::idx_window_position_low) begin : g_wlo
				assign live_value[gi] =
					core_status.window_position[15:0];
			end else if (clkbuf_regs_pkg::reg_index[gi] ==
				clkbuf_regs_pkg::idx_window_position_high) begin : g_whi
				assign live_value[gi] =
					core_status.window_position[31:16];
			end else if (clkbuf_regs_pkg::reg_index[gi] ==
				clkbuf_regs_pkg::idx_top_control) begin : g_top
				assign live_value[gi] = state_q.regs[gi] &
					clkbuf_regs_pkg::top_writable_mask;
			end else begin : g_plain
				assign live_value[gi] = state_q.regs[gi];
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Reset image
	// ------------------------------------------------------------
	always_comb begin
		state_reset = '0;
		for (int i = 0; i < clkbuf_regs_pkg::num_regs; i++) begin
			state_reset.regs[i] = clkbuf_regs_pkg::reg_reset[i];
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic take;
		logic [clkbuf_regs_pkg::reg_width-1:0] rd_value;
		logic wr_any;
		take = 1'b0;
		rd_value = '0;
		wr_any = 1'b0;
		state_d = state_q;

		// Data phase of a pending write
		if (state_q.phase.active && state_q.phase.write &&
			state_q.phase.aligned) begin
			for (int i = 0; i < clkbuf_regs_pkg::num_regs; i++) begin
				if (hit_vec[i] && !clkbuf_regs_pkg::reg_read_only[i]) begin
					state_d.regs[i] = hwdata[15:0];
					wr_any = 1'b1;
				end
			end
			if (state_q.soft_reset && wr_any) begin
				state_d.regs[0][clkbuf_regs_pkg::top_reset_bit] = 1'b0;
			end
		end

		// Address phase
		take = hsel && hready &&
			(htrans == clkbuf_regs_pkg::htrans_nonseq ||
			htrans == clkbuf_regs_pkg::htrans_seq);
		state_d.phase.active = take;
		state_d.phase.write = hwrite;
		state_d.phase.index = rd_index;
		state_d.phase.aligned = haddr[1:0] == clkbuf_regs_pkg::word_shift_zero;
		state_d.rdata = '0;
		if (take && !hwrite) begin
			for (int i = 0; i < clkbuf_regs_pkg::num_regs; i++) begin
				if (rd_hit_vec[i]) begin
					rd_value = live_value[i];
				end
			end
			state_d.rdata = {16'h0000, rd_value};
		end

		// Soft reset write restores power-on image
		if (state_d.regs[0][clkbuf_regs_pkg::top_reset_bit] &&
			!state_q.soft_reset) begin
			state_d.regs = state_reset.regs;
			state_d.regs[0][clkbuf_regs_pkg::top_reset_bit] = 1'b1;
		end
		state_d.soft_reset =
			state_d.regs[0][clkbuf_regs_pkg::top_reset_bit];
		state_d.power_down =
			state_d.regs[0][clkbuf_regs_pkg::top_power_down_bit];
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= '0;
			state_q.regs[1] <= clkbuf_regs_pkg::reg_reset[1];
			state_q.regs[2] <= clkbuf_regs_pkg::reg_reset[2];
			state_q.regs[26] <= clkbuf_regs_pkg::reg_reset[26];
			state_q.regs[27] <= clkbuf_regs_pkg::reg_reset[27];
			state_q.regs[29] <= clkbuf_regs_pkg::reg_reset[29];
			state_q.regs[32] <= clkbuf_regs_pkg::reg_reset[32];
			state_q.regs[33] <= clkbuf_regs_pkg::reg_reset[33];
			state_q.regs[34] <= clkbuf_regs_pkg::reg_reset[34];
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign hrdata = state_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign power_down = state_q.power_down;
	assign soft_reset_active = state_q.soft_reset;
	assign reg_image = state_q.regs;

endmodule

// ---- tb/clock_buffer_register_map_asserts.sv ----
// Port assertions for the clock buffer register bank
// Assumes binding to the bank top and zero wait states
`timescale 1ns/1ps
module clock_buffer_register_map_asserts (
	// Clock, reset and bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Core side
	input wire clkbuf_regs_pkg::core_status_type core_status,
	input wire logic power_down,
	input wire logic soft_reset_active,
	input wire logic [559:0] reg_image
);
	// ----------------------------------------
	// Data phase tracking and checks
	// ----------------------------------------
	logic wr_q, rd_q;
	logic [6:0] idx_q;
	wire take = hsel && hready && htrans[1] && haddr[1:0] == 2'h0;
	wire wr_ok = wr_q && (idx_q inside {7'h00, [7'h02:7'h09]});
	wire [4:0] osc = core_status.oscillator_choice_readback;
	wire [1:0] lock = core_status.lock_indicator_readback;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			idx_q <= 7'h00;
		end else begin
			wr_q <= take && hwrite;
			rd_q <= take && !hwrite;
			idx_q <= haddr[8:2];
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_top_wr;
		wr_q && idx_q == 7'h00;
	endsequence
	sequence s_top_rd;
		rd_q && idx_q == 7'h00 && !$past(wr_q);
	endsequence
	chk_reset_clear: assert property (
		$rose(hresetn) |-> !power_down && !soft_reset_active)
		else $error("Control set after reset");
	chk_pd_write: assert property (
		s_top_wr ##0 !hwdata[0] |=> power_down == $past(hwdata[2]))
		else $error("Power-down not taken");
	chk_value_hold: assert property (
		!wr_q |=> $stable(power_down) && $stable(reg_image[143:16]))
		else $error("Value changed without write");
	chk_soft_load: assert property (
		s_top_wr ##0 hwdata[0] && !soft_reset_active
		|=> soft_reset_active && reg_image[47:16] == 32'hff86_0223)
		else $error("Soft reset not loaded");
	chk_self_clear: assert property (
		wr_ok && soft_reset_active |=> !soft_reset_active)
		else $error("Soft reset bit stuck");
	chk_word_store: assert property (
		wr_q && idx_q == 7'h03 |=> reg_image[47:32] == $past(hwdata[15:0]))
		else $error("Write not stored");
	chk_top_read: assert property (
		s_top_rd |-> hrdata[31:3] == 29'h0 && hrdata[2] == $past(power_down)
		&& hrdata[0] == $past(soft_reset_active))
		else $error("Top control read wrong");
	chk_osc_read: assert property (
		rd_q && idx_q == 7'h41 |-> hrdata == {23'h22, $past(osc), 4'h0})
		else $error("Oscillator readback wrong");
	chk_lock_read: assert property (
		rd_q && idx_q == 7'h4b |-> hrdata == {22'h0, $past(lock), 8'h03})
		else $error("Lock readback wrong");
endmodule
bind clock_buffer_register_map clock_buffer_register_map_asserts i_chk (.*);

// ---- tb/tb_clock_buffer_register_map.sv ----
// Self-checking bench for the clock buffer register bank
// Assumes the package and checker are compiled first
`timescale 1ns/1ps
module tb_clock_buffer_register_map;
	// ----------------------------------------
	// Bench
	// ----------------------------------------
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic power_down, soft_reset_active;
	logic [559:0] reg_image;
	logic [63:0] rv;
	clkbuf_regs_pkg::core_status_type core_status;
	logic [15:0] m [128];
	int err_count, cmp_count, seed, k;
	assign hready = hreadyout;
	clock_buffer_register_map i_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .core_status(core_status),
		.power_down(power_down), .soft_reset_active(soft_reset_active),
		.reg_image(reg_image));
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	function automatic logic [6:0] ix(input int i);
		return clkbuf_regs_pkg::reg_index[i];
	endfunction
	function automatic logic ro(input int i);
		return clkbuf_regs_pkg::reg_read_only[i];
	endfunction
	function automatic logic [15:0] rst(input logic [6:0] i);
		case (i)
			7'h02: return 16'h0223;
			7'h03: return 16'hff86;
			7'h21: return 16'h5666;
			7'h22: return 16'h04c5;
			7'h43: return 16'h51cb;
			7'h4f: return 16'h0104;
			7'h56: return 16'h0004;
			7'h5a: return 16'h0006;
			default: return 16'h0000;
		endcase
	endfunction
	function automatic logic [31:0] exp_rd(input logic [6:0] i);
		case (i)
			7'h0b: return {16'h0, core_status.window_position[15:0]};
			7'h0c: return {16'h0, core_status.window_position[31:16]};
			7'h41: return {23'h22, core_status.oscillator_choice_readback, 4'h0};
			7'h4b: return {22'h0, core_status.lock_indicator_readback, 8'h03};
			default: return {16'h0, m[i]};
		endcase
	endfunction
	task automatic bus(input logic w, input logic [6:0] i,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {23'h0, i, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [6:0] i, input logic [31:0] e);
		@(posedge hclk);
		bus(1'b0, i, 32'h0, rd);
		chk(rd, e);
	endtask
	task automatic rd_all;
		for (k = 0; k < 35; k++) rd_chk(ix(k), exp_rd(ix(k)));
	endtask
	task final_report;
		$display("Comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		#(40 * 20000);
		err_count++;
		final_report;
	end
	initial begin
		seed = 50;
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		core_status = '0;
		for (k = 0; k < 128; k++) m[k] = rst(k[6:0]);
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({30'h0, power_down, soft_reset_active}, 32'h0);
		chk({30'h0, hresp, hreadyout}, 32'h1);
		rd_all;
		$display("Test reset values done");
		bus(1'b1, 7'h00, 32'h1, rd);
		for (k = 34; k > 0; k--) if (!ro(k)) begin
			rv = {$random(seed), $random(seed)};
			m[ix(k)] = rv[15:0];
			bus(1'b1, ix(k), rv[31:0], rd);
		end
		rv = {$random(seed), $random(seed)};
		core_status <= rv[38:0];
		bus(1'b1, 7'h41, 32'hffff_ffff, rd);
		bus(1'b1, 7'h4b, 32'hffff_ffff, rd);
		rd_all;
		rd_chk(7'h01, 32'h0);
		$display("Test random writes done");
		bus(1'b1, 7'h00, 32'hffff_fff8, rd);
		rd_chk(7'h00, 32'h0);
		bus(1'b1, 7'h00, 32'h0000_fff4, rd);
		rd_chk(7'h00, 32'h4);
		chk({31'h0, power_down}, 32'h1);
		m[0] = 16'h0004;
		rd_all;
		bus(1'b1, 7'h00, 32'h0, rd);
		m[0] = 16'h0000;
		rd_chk(7'h00, 32'h0);
		chk({31'h0, power_down}, 32'h0);
		$display("Test power-down done");
		bus(1'b1, 7'h00, 32'h1, rd);
		rd_chk(7'h00, 32'h1);
		chk({31'h0, soft_reset_active}, 32'h1);
		for (k = 1; k < 128; k++) m[k] = rst(k[6:0]);
		m[0] = 16'h0001;
		rd_all;
		bus(1'b1, 7'h03, 32'h0000_1234, rd);
		m[3] = 16'h1234;
		m[0] = 16'h0000;
		rd_chk(7'h00, 32'h0);
		rd_chk(7'h03, 32'h1234);
		$display("Test soft reset done");
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk(7'h03, 32'hff86);
		$display("Test second reset done");
		final_report;
	end
endmodule
